// ### rtl/sdlc_top.sv
// serial converter load control with axi4-lite register access
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module sdlc_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        serial_clk,
   input  wire logic        frame_sel_n,
   input  wire logic        serial_in,
   input  wire logic        load_output_n,
   input  wire logic        clear_output_n,
   input  wire logic        power_down_n,
   output logic             serial_out,
   output logic             serial_out_oe,
   output logic [14:0]      segment_switches,
   output logic [11:0]      ladder_switches,
   output logic             output_zero,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef struct packed {
      sdlc_pkg::sdlc_state_e state;
      logic                  sclk_q;
      logic                  frame_q;
      logic                  load_output_n_q;
      logic [15:0]           shift;
      logic [4:0]            cnt;
      logic [15:0]           inreg;
      logic [15:0]           dacreg;
      logic                  zero_latch;
      logic                  rate_err;
      logic [2:0]            gap;
      logic                  sw_clear;
      logic                  awrdy;
      logic                  wrdy;
      logic                  aw_have;
      logic                  w_have;
      logic [7:0]            awaddr;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arrdy;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      logic [14:0]           seg;
      logic [11:0]           lad;
      logic                  out_zero;
      logic                  sdo_oe;
   } sdlc_state_s;

   sdlc_state_s st_reg;
   sdlc_state_s st_next;

   // pins: clocks and levels from the outside world
   logic [5:0] pin_sync;
   logic       s_sclk;
   logic       s_frame_n;
   logic       s_serial_in;
   logic       s_load_output_n_n;
   logic       s_clr_n;
   logic       s_pd_n;

   // idle pin levels at reset so no false edge is seen on release
   sdlc_sync #(
      .W    (6),
      .INIT (6'h3F)
   ) u_pin_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({serial_clk, frame_sel_n, serial_in,
                 load_output_n, clear_output_n, power_down_n}),
      .q       (pin_sync)
   );

   assign s_sclk    = pin_sync[5];
   assign s_frame_n = pin_sync[4];
   assign s_serial_in    = pin_sync[3];
   assign s_load_output_n_n  = pin_sync[2];
   assign s_clr_n   = pin_sync[1];
   assign s_pd_n    = pin_sync[0];

   // thermometer decode of the top nibble
   function automatic logic [14:0] thermo(input logic [3:0] nib);
      logic [14:0] t;
      t = '0;
      for (int i = 0; i < sdlc_pkg::SEG_N; i++) begin
         t[i] = (nib > 4'(i));
      end
      return t;
   endfunction

   // register read data of one word
   function automatic logic [31:0] rd_word(input sdlc_state_s s,
                                           input logic [7:0]  a);
      logic [31:0] v;
      v = '0;
      case (a)
         sdlc_pkg::OFS_CTRL: begin
            v[sdlc_pkg::CTRL_SW_CLEAR] = s.sw_clear;
         end
         sdlc_pkg::OFS_INPUT: begin
            v[15:0] = s.inreg;
         end
         sdlc_pkg::OFS_DAC: begin
            v[15:0] = s.dacreg;
         end
         sdlc_pkg::OFS_STATUS: begin
            v[sdlc_pkg::STA_ZERO]     = s.out_zero;
            v[sdlc_pkg::STA_PD]       = ~s_pd_n;
            v[sdlc_pkg::STA_FRAME]    = (s.state == sdlc_pkg::ST_SHIFT);
            v[sdlc_pkg::STA_RATE_ERR] = s.rate_err;
            v[sdlc_pkg::STA_CNT_LSB +: sdlc_pkg::CNT_W] = s.cnt;
         end
         default: begin
            v = '0;
         end
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a == sdlc_pkg::OFS_CTRL) || (a == sdlc_pkg::OFS_INPUT) ||
             (a == sdlc_pkg::OFS_DAC)  || (a == sdlc_pkg::OFS_STATUS);
   endfunction

   // whole next state of the block
   always_comb begin
      logic        sclk_fall;
      logic        sclk_edge;
      logic        frame_rise;
      logic        frame_fall;
      logic        load_output_n_fall;
      logic        sw_load;
      logic        clr_n_eff;
      logic        word_done;
      logic        do_write;
      logic        rate_hit;
      logic [15:0] code;
      sclk_fall  = 1'b0;
      sclk_edge  = 1'b0;
      frame_rise = 1'b0;
      frame_fall = 1'b0;
      load_output_n_fall  = 1'b0;
      sw_load    = 1'b0;
      clr_n_eff  = 1'b1;
      word_done  = 1'b0;
      do_write   = 1'b0;
      rate_hit   = 1'b0;
      code       = '0;
      st_next    = st_reg;

      st_next.sclk_q  = s_sclk;
      st_next.frame_q = s_frame_n;
      st_next.load_output_n_q  = s_load_output_n_n;
      sclk_edge  = (st_reg.sclk_q != s_sclk);
      sclk_fall  = st_reg.sclk_q & ~s_sclk;
      frame_fall = st_reg.frame_q & ~s_frame_n;
      frame_rise = ~st_reg.frame_q & s_frame_n;
      load_output_n_fall  = st_reg.load_output_n_q & ~s_load_output_n_n;

      // axi write: address and data taken in either order
      if (s_axi_awvalid && st_reg.awrdy) begin
         st_next.aw_have = 1'b1;
         st_next.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.wrdy) begin
         st_next.w_have = 1'b1;
         st_next.wdata  = s_axi_wdata;
         st_next.wstrb  = s_axi_wstrb;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      do_write = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
      if (do_write) begin
         st_next.aw_have = 1'b0;
         st_next.w_have  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = mapped(st_reg.awaddr) ? sdlc_pkg::RESP_OKAY
                                                 : sdlc_pkg::RESP_SLVERR;
         if (st_reg.awaddr == sdlc_pkg::OFS_CTRL && st_reg.wstrb[0]) begin
            st_next.sw_clear = st_reg.wdata[sdlc_pkg::CTRL_SW_CLEAR];
            sw_load          = st_reg.wdata[sdlc_pkg::CTRL_SW_LOAD];
         end
      end
      st_next.awrdy = !st_next.aw_have;
      st_next.wrdy  = !st_next.w_have;

      // axi read: one word, answered the cycle after the address
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_reg.arrdy) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = rd_word(st_reg, s_axi_araddr);
         st_next.rresp  = mapped(s_axi_araddr) ? sdlc_pkg::RESP_OKAY
                                               : sdlc_pkg::RESP_SLVERR;
      end
      st_next.arrdy = !st_next.rvalid;

      // serial clock spacing watch; bursts too fast for the sampler
      // are flagged, the word is still taken as seen
      if (sclk_edge) begin
         st_next.gap = '0;
         rate_hit    = (st_reg.state == sdlc_pkg::ST_SHIFT) &&
                       (st_reg.gap < 3'(sdlc_pkg::LINK_HALF_CYC));
      end else if (st_reg.gap != 3'h7) begin
         st_next.gap = st_reg.gap + 3'h1;
      end

      // frame sequencer
      case (st_reg.state)
         sdlc_pkg::ST_IDLE: begin
            if (frame_fall) begin
               st_next.state = sdlc_pkg::ST_SHIFT;
               st_next.cnt   = '0;
               st_next.shift = st_reg.dacreg;  // readback source
            end
         end
         sdlc_pkg::ST_SHIFT: begin
            if (frame_rise) begin
               st_next.state = sdlc_pkg::ST_IDLE;
               word_done = (st_reg.cnt >= sdlc_pkg::WORD_CNT);
            end else if (sclk_fall) begin
               st_next.shift = {st_reg.shift[14:0], s_serial_in};
               if (st_reg.cnt != sdlc_pkg::WORD_CNT) begin
                  st_next.cnt = st_reg.cnt + 5'h01;
               end
            end
         end
         default: begin
            st_next.state = sdlc_pkg::ST_IDLE;
         end
      endcase

      // load paths; clear and power-down never block register writes
      if (word_done) begin
         st_next.inreg = st_reg.shift;
         if (!s_load_output_n_n) begin
            st_next.dacreg = st_reg.shift;
         end
      end else if ((load_output_n_fall && st_reg.state == sdlc_pkg::ST_IDLE) ||
                   sw_load) begin
         st_next.dacreg = st_reg.inreg;
      end

      // clear latch holds zero until clear is released while load is low or a software load comes
      clr_n_eff = s_clr_n & ~st_reg.sw_clear;
      if (!clr_n_eff) begin
         st_next.zero_latch = 1'b1;
      end else if (!s_load_output_n_n || sw_load) begin
         st_next.zero_latch = 1'b0;
      end

      // rate flag: set wins over a write-one clear
      if (do_write && st_reg.awaddr == sdlc_pkg::OFS_STATUS &&
          st_reg.wstrb[0] && st_reg.wdata[sdlc_pkg::STA_RATE_ERR]) begin
         st_next.rate_err = 1'b0;
      end
      if (rate_hit) begin
         st_next.rate_err = 1'b1;
      end

      // switch drive: midscale code is 0 V, registers left intact
      st_next.out_zero = !s_pd_n || st_next.zero_latch;
      code = st_next.out_zero ? sdlc_pkg::MIDSCALE
                              : st_next.dacreg;
      st_next.seg = thermo(code[15:12]);
      st_next.lad = code[11:0];

      // open drain pulls low for a zero msb, off in power-down
      st_next.sdo_oe = s_pd_n && !st_next.shift[15];
   end

   // single state register; power-on loads midscale
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg            <= '0;
         st_reg.state      <= sdlc_pkg::ST_IDLE;
         st_reg.sclk_q     <= 1'b1;
         st_reg.frame_q    <= 1'b1;
         st_reg.load_output_n_q     <= 1'b1;
         st_reg.shift      <= sdlc_pkg::MIDSCALE;
         st_reg.inreg      <= sdlc_pkg::MIDSCALE;
         st_reg.dacreg     <= sdlc_pkg::MIDSCALE;
         st_reg.gap        <= 3'h7;
         st_reg.awrdy      <= 1'b1;
         st_reg.wrdy       <= 1'b1;
         st_reg.arrdy      <= 1'b1;
         st_reg.seg        <= thermo(sdlc_pkg::MIDSCALE[15:12]);
         st_reg.lad        <= sdlc_pkg::MIDSCALE[11:0];
      end else begin
         st_reg <= st_next;
      end
   end

   // every output but serial_out, which is tied low, straight from the state register
   assign serial_out       = 1'b0;
   assign serial_out_oe    = st_reg.sdo_oe;
   assign segment_switches = st_reg.seg;
   assign ladder_switches  = st_reg.lad;
   assign output_zero      = st_reg.out_zero;
   assign s_axi_awready    = st_reg.awrdy;
   assign s_axi_wready     = st_reg.wrdy;
   assign s_axi_bvalid     = st_reg.bvalid;
   assign s_axi_bresp      = st_reg.bresp;
   assign s_axi_arready    = st_reg.arrdy;
   assign s_axi_rvalid     = st_reg.rvalid;
   assign s_axi_rdata      = st_reg.rdata;
   assign s_axi_rresp      = st_reg.rresp;
endmodule

// ### rtl/sdlc_pkg.sv
// constants, types and register map of the serial converter load control
package sdlc_pkg;
   localparam int          WORD_BITS  = 16;
   localparam int          SEG_N      = 15;
   localparam int          LAD_N      = 12;
   localparam int          CNT_W      = 5;
   localparam logic [4:0]  WORD_CNT   = 5'h10;
   localparam logic [15:0] MIDSCALE   = 16'h8000;

   // fastest legal serial clock, half period in ns, and in system cycles
   localparam int          SYS_CLK_NS     = 20;
   localparam int          LINK_HALF_NS   = 50;
   localparam int          LINK_HALF_CYC  = LINK_HALF_NS / SYS_CLK_NS;
   localparam int          GAP_W          = 3;

   // register byte offsets
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_INPUT  = 8'h04;
   localparam logic [7:0]  OFS_DAC    = 8'h08;
   localparam logic [7:0]  OFS_STATUS = 8'h0C;

   // control fields
   localparam int          CTRL_SW_CLEAR = 0;
   localparam int          CTRL_SW_LOAD  = 1;
   // status fields
   localparam int          STA_ZERO      = 0;
   localparam int          STA_PD        = 1;
   localparam int          STA_FRAME     = 2;
   localparam int          STA_RATE_ERR  = 3;
   localparam int          STA_CNT_LSB   = 4;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10
   } sdlc_state_e;
endpackage

// ### rtl/sdlc_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module sdlc_sync #(
   parameter int        W      = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= INIT;
         q        <= INIT;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

// ### test/sdlc_monitor.sv
// concurrent checks on the load control ports
`timescale 1ns/100ps
module sdlc_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        frame_sel_n,
   input wire logic        load_output_n,
   input wire logic        clear_output_n,
   input wire logic        power_down_n,
   input wire logic        serial_out_oe,
   input wire logic [14:0] segment_switches,
   input wire logic [11:0] ladder_switches,
   input wire logic        output_zero,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // pins idle and no bus write: nothing may move the switches
   sequence quiet_s;
      (frame_sel_n && load_output_n && clear_output_n && power_down_n
       && !s_axi_awvalid)[*8];
   endsequence
   sequence wr_take_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   reset_mid_a: assert property ($rose(aresetn) |->
      segment_switches == 15'h00FF && ladder_switches == 12'h000)
      else $error("switches not midscale after reset");
   thermo_shape_a: assert property (
      (segment_switches & (segment_switches + 15'h0001)) == 15'h0000)
      else $error("segment switches not a thermometer");
   zero_shows_mid_a: assert property (output_zero |->
      segment_switches == 15'h00FF && ladder_switches == 12'h000)
      else $error("forced zero without midscale switches");
   clear_forces_a: assert property (
      (!clear_output_n)[*6] |-> output_zero)
      else $error("clear held low but output not zero");
   clear_hold_a: assert property ($fell(output_zero) |->
      $past(clear_output_n, 2) && $past(clear_output_n, 3))
      else $error("output left zero while clear low");
   pd_forces_a: assert property (
      (!power_down_n)[*6] |-> output_zero && !serial_out_oe)
      else $error("power-down not forcing zero and oe off");
   quiet_stable_a: assert property (quiet_s |=>
      $stable(segment_switches) && $stable(ladder_switches))
      else $error("switches moved with no load event");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   write_answer_a: assert property (wr_take_s |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after take");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid)
      else $error("read data not one cycle after take");
endmodule
bind sdlc_top sdlc_monitor mon (.*);

// ### test/sdlc_host_model.sv
// host serial port model that frames words onto the link pins
`timescale 1ns/100ps
module sdlc_host_model (
   input  wire logic aclk,
   output logic      serial_clk,
   output logic      frame_sel_n,
   output logic      serial_in
);
   // link idles with clock resting high and no frame
   initial begin
      serial_clk = 1'b1;
      frame_sel_n = 1'b1;
      serial_in = 1'b1;
   end
   // four aclk per half period gives the 160 ns link clock
   task automatic half();
      repeat (4) @(posedge aclk);
   endtask
   // n bits msb first; data changes only while the clock is high
   task automatic send(input logic [15:0] w, input int n);
      frame_sel_n <= 1'b0;
      half();
      for (int i = 0; i < n; i++) begin
         serial_in <= w[15-i];
         half();
         serial_clk <= 1'b0;
         half();
         serial_clk <= 1'b1;
      end
      half();
      frame_sel_n <= 1'b1;
      serial_in <= ~serial_in; // released line must not look held
      half();
   endtask
endmodule

// ### test/testbench.sv
// self-checking bench for the serial converter load control
`timescale 1ns/100ps
module testbench;
   logic        aclk, aresetn, serial_clk, frame_sel_n, serial_in;
   logic        load_output_n, clear_output_n, power_down_n;
   logic        serial_out, serial_out_oe, output_zero;
   logic [14:0] segment_switches;
   logic [11:0] ladder_switches;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, c, p;
   logic [31:0] rng = 32'h0000_0009;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          n_errors = 0;
   int          check_count = 0;
   wire [31:0]  sw_now = {5'h00, segment_switches, ladder_switches};
   logic [31:0] corner [4] = '{32'h0000_0000, 32'h0000_FFFF,
                               32'h0000_7FFF, 32'h0000_1000};

   sdlc_top uut (.*);
   sdlc_host_model host (.aclk, .serial_clk, .frame_sel_n, .serial_in);

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // a hang ends the run as a failure
   initial begin
      #200_000;
      n_errors++;
      test_done();
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // switch pattern a code should give: thermometer top, ladder direct
   function automatic logic [31:0] sw_of(input logic [15:0] v);
      logic [14:0] s;
      for (int i = 0; i < 15; i++)
         s[i] = (v[15:12] > i);
      return {5'h00, s, v[11:0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic zchk(input logic e);
      chk("output_zero", {31'h0, e}, {31'h0, output_zero});
   endtask
   // pin paths take a few cycles through the synchroniser
   task automatic wt();
      repeat (8) @(posedge aclk);
   endtask
   task automatic frm(input logic [15:0] v, input int n);
      host.send(v, n);
      wt();
   endtask
   // address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      axi_rd(a, d);
      chk("rdata", e, d);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // main sequence: reset, load modes, clear, power-down, bus, reset again
   initial begin
      aresetn = 1'b0;
      load_output_n = 1'b0;
      clear_output_n = 1'b1;
      power_down_n = 1'b1;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      wt();
      chk("switches", sw_of(16'h8000), sw_now);
      rdc(sdlc_pkg::OFS_DAC, 32'h0000_8000);
      rdc(sdlc_pkg::OFS_INPUT, 32'h0000_8000);
      for (int k = 0; k < 8; k++) begin
         rng = xs(rng);
         c = (k < 4) ? corner[k] : {16'h0000, rng[15:0]};
         frm(c[15:0], 16);
         chk("switches", sw_of(c[15:0]), sw_now);
         chk("oe", {31'h0, ~c[15]}, {31'h0, serial_out_oe});
         rdc(sdlc_pkg::OFS_INPUT, c);
      end
      p = c;
      c = {16'h0000, rng[31:16]};
      load_output_n <= 1'b1;
      frm(c[15:0], 16);
      chk("switches", sw_of(p[15:0]), sw_now);
      rdc(sdlc_pkg::OFS_DAC, p);
      load_output_n <= 1'b0;
      wt();
      chk("switches", sw_of(c[15:0]), sw_now);
      frm(16'h1234, 8);
      rdc(sdlc_pkg::OFS_INPUT, c);
      rdc(sdlc_pkg::OFS_STATUS, 32'h0000_0080);
      p = c;
      c = {16'h0000, ~rng[15:0]};
      load_output_n <= 1'b1;
      clear_output_n <= 1'b0;
      frm(c[15:0], 16);
      zchk(1'b1);
      rdc(sdlc_pkg::OFS_DAC, p);
      clear_output_n <= 1'b1;
      wt();
      zchk(1'b1);
      load_output_n <= 1'b0;
      wt();
      chk("switches", sw_of(c[15:0]), sw_now);
      rng = xs(rng);
      c = {16'h0000, rng[15:0]};
      clear_output_n <= 1'b0;
      frm(c[15:0], 16);
      zchk(1'b1);
      rdc(sdlc_pkg::OFS_DAC, c);
      clear_output_n <= 1'b1;
      wt();
      chk("switches", sw_of(c[15:0]), sw_now);
      rng = xs(rng);
      c = {16'h0000, rng[15:0]};
      power_down_n <= 1'b0;
      frm(c[15:0], 16);
      zchk(1'b1);
      chk("oe", 32'h0, {31'h0, serial_out_oe});
      rdc(sdlc_pkg::OFS_DAC, c);
      rdc(sdlc_pkg::OFS_STATUS, 32'h0000_0103);
      power_down_n <= 1'b1;
      wt();
      chk("switches", sw_of(c[15:0]), sw_now);
      axi_wr(8'h20, 32'h0000_0000);
      chk("bresp", 32'h2, {30'h0, r});
      axi_rd(8'h10, p);
      chk("rresp", 32'h2, {30'h0, r});
      // load pin high so only the software load can release the latch
      load_output_n <= 1'b1;
      axi_wr(sdlc_pkg::OFS_CTRL, 32'h0000_0001);
      wt();
      zchk(1'b1);
      rdc(sdlc_pkg::OFS_CTRL, 32'h0000_0001);
      axi_wr(sdlc_pkg::OFS_CTRL, 32'h0000_0000);
      wt();
      zchk(1'b1);
      axi_wr(sdlc_pkg::OFS_CTRL, 32'h0000_0002);
      wt();
      zchk(1'b0);
      chk("switches", sw_of(c[15:0]), sw_now);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wt();
      chk("switches", sw_of(16'h8000), sw_now);
      rdc(sdlc_pkg::OFS_DAC, 32'h0000_8000);
      test_done();
   end
endmodule
